/* hdl/cpg_edge_det.sv */
// rising and falling edge finder for the interrupt path
// assumes the level is already synchronous to clk_sys
`timescale 1ns/10ps
module cpg_edge_det (
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic             ce,
   input  wire cpg_pkg::cpg_vec_t lvl_i,
   output wire cpg_pkg::cpg_vec_t rise_o,
   output wire cpg_pkg::cpg_vec_t fall_o
);
   import cpg_pkg::*;

   cpg_edge_s st_q;
   cpg_edge_s st_d;

   always_comb begin
      st_d      = st_q;
      st_d.prev = lvl_i;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // edges are only meaningful in cycles where ce is high
   assign rise_o = lvl_i & ~st_q.prev;
   assign fall_o = ~lvl_i & st_q.prev;
endmodule

/* hdl/cpg_pin_group.sv */
// configurable general-purpose pin group with avalon-mm register access
// assumes pin inputs synchronous to clk_sys and an outside pad resolver
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
module cpg_pin_group #(
   parameter int          N_PINS        = 1,
   parameter bit          GROUPED       = 1'b0,
   parameter bit          CONTIG        = 1'b1,
   parameter bit          HW_OE_USED    = 1'b1,
   parameter bit          DEDICATED_IRQ = 1'b1,
   parameter logic [31:0] INIT_OUT      = 32'h0000_0000
) (
   input  wire logic                clk_sys,
   input  wire logic                reset_n,
   input  wire logic                ce,
   input  wire cpg_pkg::cpg_addr_t  avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire cpg_pkg::cpg_vec_t   avs_writedata,
   output wire cpg_pkg::cpg_vec_t   avs_readdata,
   output wire logic                avs_waitrequest,
   input  wire logic [N_PINS-1:0]   pin_in,
   output wire logic [N_PINS-1:0]   pin_out,
   output wire logic [N_PINS-1:0]   pin_oe,
   input  wire logic [N_PINS-1:0]   hw_out,
   input  wire logic [N_PINS-1:0]   hw_oe,
   output wire logic [N_PINS-1:0]   hw_in,
   input  wire logic                in_sync_ce,
   input  wire logic                in_sync_rst,
   input  wire logic                out_sync_ce,
   input  wire logic                out_sync_rst,
   output wire logic                irq_port,
   output wire logic                irq_combined
);
   import cpg_pkg::*;

   // register decode shared by the read and write paths
   function automatic logic reg_hit(input cpg_addr_t a,
                                    input cpg_addr_t off);
      reg_hit = (a == off);
   endfunction

   cpg_state_s st_q;
   cpg_state_s st_d;
   cpg_avreq_s req;
   cpg_vec_t   pmask;
   cpg_vec_t   pin_in_w;
   cpg_vec_t   hw_out_w;
   cpg_vec_t   hw_oe_w;
   cpg_vec_t   sync_lvl;
   cpg_vec_t   lvl_sel;
   cpg_vec_t   rise;
   cpg_vec_t   fall;
   cpg_vec_t   hw_oe_eff;
   cpg_vec_t   drive_out;
   cpg_vec_t   drive_oe;
   cpg_vec_t   sw_state;
   cpg_vec_t   clr;
   cpg_vec_t   ev;
   cpg_vec_t   rmux;

   // widen the pin buses to the internal register width
   assign pmask    = cpg_vec_t'({N_PINS{1'b1}});
   assign pin_in_w = cpg_vec_t'(pin_in);
   assign hw_out_w = cpg_vec_t'(hw_out);
   assign hw_oe_w  = cpg_vec_t'(hw_oe);

   // pack the bus request
   assign req.rd    = avs_read;
   assign req.wr    = avs_write;
   assign req.addr  = avs_address;
   assign req.wdata = avs_writedata;

   // input synchroniser with its own enable and reset [R15] [R16]
   cpg_sync2 u_sync (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .ce      (ce & in_sync_ce),
      .rst_in  (in_sync_rst),
      .lvl_i   (pin_in_w),
      .lvl_o   (sync_lvl)
   );

   // synchronised or transparent level for logic and interrupts [R16]
   assign lvl_sel = (st_q.ctrl_sync ? sync_lvl : pin_in_w) & pmask;

   cpg_edge_det u_edge (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .ce      (ce),
      .lvl_i   (lvl_sel),
      .rise_o  (rise),
      .fall_o  (fall)
   );

   // one shared enable in grouped view, else one per pin [R3]
   assign hw_oe_eff = GROUPED ? {CPG_MAXP{hw_oe[0]}} : hw_oe_w;

   // hardware pins take hw value and enable, software pins the
   // registers; a bidirectional pin is just hw in plus hw out [R1] [R2]
   // [R4] [R6] [R14]
   assign drive_out = (st_q.hwsel & hw_out_w) | (~st_q.hwsel & st_q.out);
   assign drive_oe  = (st_q.hwsel & (HW_OE_USED ? hw_oe_eff : pmask))
                    | (~st_q.hwsel & st_q.drv);

   // software view of the pins is the raw level behind the input
   // buffer, so the sync choice never reaches it [R5] [R7] [R8]
   assign sw_state = pin_in_w & st_q.ibuf & pmask;

   // read multiplexer; the out and state registers read zero for split groups [R9]
   always_comb begin
      rmux = '0;
      if (reg_hit(req.addr, CPG_OFF_CTRL)) begin
         rmux[CPG_CTRL_SYNC] = st_q.ctrl_sync;
         rmux[CPG_CTRL_DIRQ] = DEDICATED_IRQ;
      end else if (reg_hit(req.addr, CPG_OFF_OUT)) begin
         rmux = CONTIG ? st_q.out : '0;
      end else if (reg_hit(req.addr, CPG_OFF_DRV)) begin
         rmux = st_q.drv;
      end else if (reg_hit(req.addr, CPG_OFF_IBUF)) begin
         rmux = st_q.ibuf;
      end else if (reg_hit(req.addr, CPG_OFF_HWSEL)) begin
         rmux = st_q.hwsel;
      end else if (reg_hit(req.addr, CPG_OFF_STATE)) begin
         rmux = CONTIG ? sw_state : '0;
      end else if (reg_hit(req.addr, CPG_OFF_STAT)) begin
         rmux = st_q.stat;
      end else if (reg_hit(req.addr, CPG_OFF_MASK)) begin
         rmux = st_q.mask;
      end else if (reg_hit(req.addr, CPG_OFF_RISE)) begin
         rmux = st_q.k_rise;
      end else if (reg_hit(req.addr, CPG_OFF_FALL)) begin
         rmux = st_q.k_fall;
      end else if (reg_hit(req.addr, CPG_OFF_PACC)) begin
         rmux[CPG_PACC_IDX +: CPG_PACC_IDXW] = st_q.acc_idx;
         rmux[CPG_PACC_VAL] = sw_state[st_q.acc_idx[4:0]];
      end
   end

   // next-state logic: bus slave, pin drivers and interrupt status
   always_comb begin
      st_d = st_q;
      clr  = '0;
      ev   = '0;

      // two-cycle slave: answer one cycle after the request, and the
      // write lands on the edge where the master sees waitrequest low
      unique case (st_q.bus)
         CPG_BUS_IDLE: begin
            if (req.rd || req.wr) begin
               st_d.bus     = CPG_BUS_ANS;
               st_d.waitreq = 1'b0;
               st_d.rdata   = req.rd ? rmux : '0;
            end
         end
         CPG_BUS_ANS: begin
            st_d.bus     = CPG_BUS_IDLE;
            st_d.waitreq = 1'b1;
            if (req.wr) begin
               if (reg_hit(req.addr, CPG_OFF_CTRL)) begin
                  st_d.ctrl_sync = req.wdata[CPG_CTRL_SYNC];
               end
               // whole-group writes only where the group is one port [R9]
               if (reg_hit(req.addr, CPG_OFF_OUT) && CONTIG) begin
                  st_d.out = req.wdata & pmask; // [R6]
               end
               if (reg_hit(req.addr, CPG_OFF_DRV)) begin
                  st_d.drv = req.wdata & pmask;
               end
               if (reg_hit(req.addr, CPG_OFF_IBUF)) begin
                  st_d.ibuf = req.wdata & pmask;
               end
               if (reg_hit(req.addr, CPG_OFF_HWSEL)) begin
                  st_d.hwsel = req.wdata & pmask;
               end
               if (reg_hit(req.addr, CPG_OFF_STAT)) begin
                  clr = req.wdata;
               end
               if (reg_hit(req.addr, CPG_OFF_MASK)) begin
                  st_d.mask = req.wdata & pmask;
               end
               if (reg_hit(req.addr, CPG_OFF_RISE)) begin
                  st_d.k_rise = req.wdata & pmask;
               end
               if (reg_hit(req.addr, CPG_OFF_FALL)) begin
                  st_d.k_fall = req.wdata & pmask;
               end
               // per-pin path works for any group shape [R9]
               if (reg_hit(req.addr, CPG_OFF_PACC)) begin
                  st_d.acc_idx = req.wdata[CPG_PACC_IDX +: CPG_PACC_IDXW];
                  if (req.wdata[CPG_PACC_IDX +: CPG_PACC_IDXW] < N_PINS)
                  begin
                     st_d.out[req.wdata[4:0]] = req.wdata[CPG_PACC_VAL];
                  end
               end
            end
         end
      endcase

      // routed input for internal logic, synchronised when chosen [R16]
      st_d.hw_in = lvl_sel;

      // output stage with its own enable and reset; reset floats all
      // drivers so nothing fights the board before setup [R15] [R17]
      if (out_sync_rst) begin
         st_d.pin_oe = '0;
      end else if (out_sync_ce) begin
         st_d.pin_out = drive_out & pmask;
         st_d.pin_oe  = drive_oe & pmask;
      end

      // only pins with an input buffer may raise interrupts [R11]
      ev = ((rise & st_q.k_rise) | (fall & st_q.k_fall)) & st_q.ibuf;
      // sticky status: a new event beats a same-cycle clear
      st_d.stat = ((st_q.stat & ~clr) | ev) & pmask;

      // combined line always, dedicated line only when selected [R10]
      st_d.irq_comb = |(st_d.stat & st_d.mask);
      st_d.irq_port = DEDICATED_IRQ & st_d.irq_comb;
   end

   // single state register; ce low freezes everything
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         st_q         <= CPG_STATE_RST;
         st_q.out     <= INIT_OUT & cpg_vec_t'({N_PINS{1'b1}});
         st_q.pin_out <= INIT_OUT & cpg_vec_t'({N_PINS{1'b1}});
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // every output straight from the state register
   assign avs_readdata    = st_q.rdata;
   assign avs_waitrequest = st_q.waitreq;
   assign pin_out         = st_q.pin_out[N_PINS-1:0];
   assign pin_oe          = st_q.pin_oe[N_PINS-1:0];
   assign hw_in           = st_q.hw_in[N_PINS-1:0];
   assign irq_port        = st_q.irq_port;
   assign irq_combined    = st_q.irq_comb;

   // checks on the pin drivers, bus timing and interrupt path
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   // output stage is live this cycle
   logic out_live;
   assign out_live = ce && out_sync_ce && !out_sync_rst;

   a_hw_oe_on: assert property ( // [R1]
      out_live && st_q.hwsel[0] && hw_oe[0]
      |=> pin_oe[0] && (pin_out[0] == $past(hw_out[0])))
      else $error("hw driven pin not enabled by its output enable");

   a_hw_oe_off: assert property ( // [R2]
      HW_OE_USED && out_live && st_q.hwsel[0] && !hw_oe[0] && !GROUPED
      |=> !pin_oe[0])
      else $error("hw driven pin still driven with enable low");

   a_group_oe_shared: assert property ( // [R3]
      GROUPED && HW_OE_USED && out_live
      && (st_q.hwsel[N_PINS-1:0] == {N_PINS{1'b1}})
      |=> pin_oe == {N_PINS{$past(hw_oe[0])}})
      else $error("grouped pins do not share the first enable");

   a_sw_oe_regs: assert property ( // [R4]
      out_live && !st_q.hwsel[0]
      |=> pin_oe[0] == $past(st_q.drv[0]))
      else $error("software pin enable not taken from its register");

   a_state_readback: assert property ( // [R7]
      ce && st_q.bus == CPG_BUS_IDLE && avs_read && CONTIG
      && avs_address == CPG_OFF_STATE
      |=> !avs_waitrequest
          && avs_readdata == ($past(pin_in_w) & $past(st_q.ibuf) & pmask))
      else $error("pin state read does not match buffered pin level");

   a_wait_one_cycle: assert property ( // [R5]
      ce && !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");

   a_sync_two_flops: assert property ( // [R16]
      (ce && in_sync_ce && !in_sync_rst && st_q.ctrl_sync)[*3]
      |=> hw_in[0] == $past(pin_in[0], 3))
      else $error("synchronised input not delayed by two stages");

   a_irq_port_gate: assert property ( // [R10]
      irq_port == (DEDICATED_IRQ && irq_combined))
      else $error("dedicated interrupt exposed while not selected");

   a_irq_input_only: assert property ( // [R11]
      $rose(st_q.stat[0]) |-> $past(st_q.ibuf[0]))
      else $error("interrupt raised on pin without input buffer");

   a_reset_hiz: assert property ( // [R17]
      $rose(reset_n) |-> pin_oe == '0)
      else $error("driver enabled right after reset");

endmodule

/* hdl/cpg_pkg.sv */
// constants, types and state records for the configurable pin group
// assumes one system clock, synchronous active-low reset, avalon-mm access
//
// Operation
// R1: hardware output enable high turns the pin driver on as configured.
// R2: hardware output enable low turns the driver off, pin floats.
// R3: grouped view shares one output enable, else one enable per pin.
// R4: output enable acts only on hardware-driven pins, not software ones.
// R5: every input pin state is readable by software.
// R6: software writes the output level; hardware may drive it instead.
// R7: a software pin reads back only with its input buffer enabled.
// R8: input synchronisation does not affect software-only reads.
// R9: group register access only for contiguous single-port groups.
// R10: dedicated interrupt only when selected; combined interrupt always works.
// R11: pin interrupts exist only where a digital input path exists.
// R12: wake interrupts must be level or derived at the controller.
// R13: routed input may feed a level interrupt through general routing.
// R14: bidirectional pin equals hardware input plus hardware output.
// R15: synchronisers have their own enable and reset when not transparent.
// R16: synchronised input passes two flops before logic or interrupts.
// R17: after reset every driver is off or at its initial level.
package cpg_pkg;

   localparam int CPG_MAXP = 32;
   typedef logic [CPG_MAXP-1:0] cpg_vec_t;
   typedef logic [7:0]          cpg_addr_t;

   // register byte offsets
   localparam cpg_addr_t CPG_OFF_CTRL  = 8'h00;
   localparam cpg_addr_t CPG_OFF_OUT   = 8'h04;
   localparam cpg_addr_t CPG_OFF_DRV   = 8'h08;
   localparam cpg_addr_t CPG_OFF_IBUF  = 8'h0C;
   localparam cpg_addr_t CPG_OFF_HWSEL = 8'h10;
   localparam cpg_addr_t CPG_OFF_STATE = 8'h14;
   localparam cpg_addr_t CPG_OFF_STAT  = 8'h18;
   localparam cpg_addr_t CPG_OFF_MASK  = 8'h1C;
   localparam cpg_addr_t CPG_OFF_RISE  = 8'h20;
   localparam cpg_addr_t CPG_OFF_FALL  = 8'h24;
   localparam cpg_addr_t CPG_OFF_PACC  = 8'h28;

   // field positions
   localparam int CPG_CTRL_SYNC = 0;
   localparam int CPG_CTRL_DIRQ = 1;
   localparam int CPG_PACC_IDX  = 0;
   localparam int CPG_PACC_IDXW = 6;
   localparam int CPG_PACC_VAL  = 8;

   // reset values
   localparam cpg_vec_t CPG_RST_VEC  = 32'h0000_0000;
   localparam logic     CPG_RST_SYNC = 1'b0;

   typedef enum logic {
      CPG_BUS_IDLE,
      CPG_BUS_ANS
   } cpg_bus_e;

   // avalon request carried as one record
   typedef struct packed {
      logic      rd;
      logic      wr;
      cpg_addr_t addr;
      cpg_vec_t  wdata;
   } cpg_avreq_s;

   typedef struct packed {
      cpg_bus_e                 bus;
      logic                     waitreq;
      cpg_vec_t                 rdata;
      logic                     ctrl_sync;
      cpg_vec_t                 out;
      cpg_vec_t                 drv;
      cpg_vec_t                 ibuf;
      cpg_vec_t                 hwsel;
      cpg_vec_t                 stat;
      cpg_vec_t                 mask;
      cpg_vec_t                 k_rise;
      cpg_vec_t                 k_fall;
      logic [CPG_PACC_IDXW-1:0] acc_idx;
      cpg_vec_t                 pin_out;
      cpg_vec_t                 pin_oe;
      cpg_vec_t                 hw_in;
      logic                     irq_port;
      logic                     irq_comb;
   } cpg_state_s;

   localparam cpg_state_s CPG_STATE_RST = '{
      bus: CPG_BUS_IDLE, waitreq: 1'b1, ctrl_sync: CPG_RST_SYNC,
      acc_idx: 6'h00, irq_port: 1'b0, irq_comb: 1'b0,
      default: CPG_RST_VEC};

   typedef struct packed {
      cpg_vec_t s1;
      cpg_vec_t s2;
   } cpg_sync_s;

   typedef struct packed {
      cpg_vec_t prev;
   } cpg_edge_s;

endpackage

/* hdl/cpg_sync2.sv */
// two-stage input synchroniser for all pins of the group
// assumes ce freezes it and rst_in clears it synchronously
`timescale 1ns/10ps
module cpg_sync2 (
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic             ce,
   input  wire logic             rst_in,
   input  wire cpg_pkg::cpg_vec_t lvl_i,
   output wire cpg_pkg::cpg_vec_t lvl_o
);
   import cpg_pkg::*;

   cpg_sync_s st_q;
   cpg_sync_s st_d;

   // first stage feeds only the second stage
   always_comb begin
      st_d    = st_q;
      st_d.s1 = lvl_i;
      st_d.s2 = st_q.s1;
      if (rst_in) begin
         st_d = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign lvl_o = st_q.s2;
endmodule

/* test/configurable_pin_group_bench.sv */
// self-checking bench for the pin group: avalon master, pads, irqs
// assumes the pad model below stands for everything off chip
`timescale 1ns/10ps
module configurable_pin_group_bench;
   import cpg_pkg::*;
   localparam int       NP   = 4;
   localparam cpg_vec_t PM   = 32'h0000_000F;
   localparam cpg_vec_t INIT = 32'h0000_0005;
   logic          clk_sys, reset_n, ce, avs_read, avs_write;
   logic          avs_waitrequest, irq_port, irq_combined, irq_port_g;
   logic          in_sync_ce, in_sync_rst, out_sync_ce, out_sync_rst;
   cpg_addr_t     avs_address;
   cpg_vec_t      avs_writedata, avs_readdata, rd, a, b, s, x, y, c;
   cpg_vec_t      rd_data_g, rd_g, p;
   logic [NP-1:0] pin_in, pin_out, pin_oe, hw_out, hw_oe, hw_in;
   logic [NP-1:0] ext_en, ext_val, pin_oe_g;
   int            mismatches, checks;

   cpg_pin_group #(.N_PINS(NP), .INIT_OUT(INIT)) cpg_pin_group_i (
      .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .hw_out(hw_out), .hw_oe(hw_oe), .hw_in(hw_in),
      .in_sync_ce(in_sync_ce), .in_sync_rst(in_sync_rst),
      .out_sync_ce(out_sync_ce), .out_sync_rst(out_sync_rst),
      .irq_port(irq_port), .irq_combined(irq_combined));

   cpg_pad_model #(.N(NP)) cpg_pad_model_i (
      .pad_out(pin_out), .pad_oe(pin_oe), .ext_en(ext_en),
      .ext_val(ext_val), .pad_lvl(pin_in));

   // second group on the same bus: one shared enable, split port and
   // no dedicated interrupt line, so those decodes get exercised too
   cpg_pin_group #(.N_PINS(NP), .GROUPED(1'b1), .CONTIG(1'b0),
                   .DEDICATED_IRQ(1'b0)) grp_cpg_pin_group_i (
      .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(rd_data_g), .avs_waitrequest(),
      .pin_in(pin_in), .pin_out(), .pin_oe(pin_oe_g),
      .hw_out(hw_out), .hw_oe(hw_oe), .hw_in(),
      .in_sync_ce(in_sync_ce), .in_sync_rst(in_sync_rst),
      .out_sync_ce(out_sync_ce), .out_sync_rst(out_sync_rst),
      .irq_port(irq_port_g), .irq_combined());

   // 25 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic stop_test();
      if (mismatches == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input cpg_vec_t seen, input cpg_vec_t exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one avalon transfer; the request stands until the trigger_a that
   // samples waitrequest low, data are taken and released at that edge
   task automatic bus(input logic wr, input cpg_addr_t adr,
                      input cpg_vec_t wd, output cpg_vec_t rdv);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_read      <= ~wr;
      avs_write     <= wr;
      avs_address   <= adr;
      avs_writedata <= wd;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      if (avs_waitrequest !== 1'b0) begin
         mismatches++;
         stop_test();
      end else begin
         rdv = avs_readdata;
         rd_g = rd_data_g;
         avs_read  <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask

   task automatic wr(input cpg_addr_t adr, input cpg_vec_t d);
      cpg_vec_t t;
      bus(1'b1, adr, d, t);
   endtask

   task automatic rchk(input cpg_addr_t adr, input cpg_vec_t exp);
      bus(1'b0, adr, 32'h0000_0000, rd);
      chk(rd, exp);
   endtask

   // outputs are levels; four edges cover the pin and input latencies
   task automatic settle();
      repeat (4) @(posedge clk_sys);
      #1;
   endtask

   function automatic cpg_vec_t mux(cpg_vec_t sel, cpg_vec_t h,
                                    cpg_vec_t sw);
      return ((sel & h) | (~sel & sw)) & PM;
   endfunction

   // released pads read high through the pull-up
   function automatic cpg_vec_t pad(cpg_vec_t oe, cpg_vec_t v);
      return ((oe & v) | ~oe) & PM;
   endfunction

   // hang guard
   initial begin
      #800000;
      mismatches++;
      stop_test();
   end

   // main sequence
   initial begin
      mismatches = 0;
      checks = 0;
      {reset_n, avs_read, avs_write, in_sync_rst, out_sync_rst} = 5'h00;
      {ce, in_sync_ce, out_sync_ce} = 3'h7;
      avs_address = 8'h00;
      avs_writedata = 32'h0000_0000;
      hw_out = 4'h0;
      hw_oe = 4'hF;
      ext_en = 4'h0;
      ext_val = 4'h0;
      rd = $urandom(32'h6cc7);
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      #1;
      chk(cpg_vec_t'(pin_oe), 32'h0000_0000);
      chk(cpg_vec_t'(pin_out), INIT);
      rchk(CPG_OFF_CTRL, 32'h0000_0002);
      chk(rd_g, 32'h0000_0000);
      rchk(CPG_OFF_OUT, INIT);
      chk(rd_g, 32'h0000_0000);
      for (int o = 8; o <= 36; o += 4)
         rchk(cpg_addr_t'(o), 32'h0000_0000);
      wr(8'h3C, 32'hFFFF_FFFF);
      rchk(8'h3C, 32'h0000_0000);
      // random mixes of software and hardware pins
      for (int k = 0; k < 12; k++) begin
         a = $urandom & PM;
         b = $urandom & PM;
         s = $urandom & PM;
         c = $urandom & PM;
         x = $urandom & PM;
         y = $urandom & PM;
         if (k == 0)
            {s, y} = {PM, 32'h0000_0000};
         wr(CPG_OFF_OUT, a);
         wr(CPG_OFF_DRV, b);
         wr(CPG_OFF_HWSEL, s);
         wr(CPG_OFF_IBUF, c);
         wr(CPG_OFF_CTRL, cpg_vec_t'(k % 2));
         @(posedge clk_sys);
         hw_out <= x[NP-1:0];
         hw_oe  <= y[NP-1:0];
         settle();
         chk(cpg_vec_t'(pin_out), mux(s, x, a));
         chk(cpg_vec_t'(pin_oe), mux(s, y, b));
         chk(cpg_vec_t'(pin_oe_g), mux(s, {32{y[0]}}, b));
         p = pad(mux(s, y, b), mux(s, x, a));
         chk(cpg_vec_t'(hw_in), p);
         rchk(CPG_OFF_STATE, p & c);
         chk(rd_g, 32'h0000_0000);
      end
      // output stage clear drops every driver
      @(posedge clk_sys);
      out_sync_rst <= 1'b1;
      settle();
      chk(cpg_vec_t'(pin_oe), 32'h0000_0000);
      @(posedge clk_sys);
      out_sync_rst <= 1'b0;
      wr(CPG_OFF_HWSEL, 32'h0000_0000);
      wr(CPG_OFF_DRV, 32'h0000_0000);
      @(posedge clk_sys);
      ext_en <= 4'hF;
      // input path latency: one edge transparent, three synchronised
      for (int m = 0; m < 2; m++) begin
         wr(CPG_OFF_CTRL, cpg_vec_t'(m));
         settle();
         @(posedge clk_sys);
         ext_val <= ~ext_val;
         repeat (2 * m) @(posedge clk_sys);
         #1;
         chk(cpg_vec_t'(hw_in), {28'h000_0000, ~ext_val});
         @(posedge clk_sys);
         #1;
         chk(cpg_vec_t'(hw_in), cpg_vec_t'(ext_val));
      end
      // clock enable low freezes the input path
      @(posedge clk_sys);
      ce <= 1'b0;
      ext_val <= ~ext_val;
      settle();
      chk(cpg_vec_t'(hw_in), {28'h000_0000, ~ext_val});
      @(posedge clk_sys);
      ce <= 1'b1;
      // edge interrupts: rise, mask, clear, fall, no input buffer
      wr(CPG_OFF_CTRL, 32'h0000_0000);
      @(posedge clk_sys);
      ext_val <= 4'h0;
      wr(CPG_OFF_IBUF, PM);
      wr(CPG_OFF_MASK, 32'h0000_0004);
      wr(CPG_OFF_STAT, PM);
      wr(CPG_OFF_RISE, 32'h0000_0004);
      rchk(CPG_OFF_STAT, 32'h0000_0000);
      @(posedge clk_sys);
      ext_val <= 4'h4;
      settle();
      chk(cpg_vec_t'({irq_port, irq_combined}), 32'h0000_0003);
      chk(cpg_vec_t'(irq_port_g), 32'h0000_0000);
      rchk(CPG_OFF_STAT, 32'h0000_0004);
      wr(CPG_OFF_MASK, 32'h0000_0000);
      settle();
      chk(cpg_vec_t'({irq_port, irq_combined}), 32'h0000_0000);
      rchk(CPG_OFF_STAT, 32'h0000_0004);
      wr(CPG_OFF_MASK, 32'h0000_0004);
      wr(CPG_OFF_STAT, 32'h0000_0004);
      settle();
      chk(cpg_vec_t'({irq_port, irq_combined}), 32'h0000_0000);
      wr(CPG_OFF_FALL, 32'h0000_0004);
      @(posedge clk_sys);
      ext_val <= 4'h0;
      settle();
      chk(cpg_vec_t'(irq_combined), 32'h0000_0001);
      wr(CPG_OFF_IBUF, 32'h0000_0000);
      wr(CPG_OFF_STAT, PM);
      @(posedge clk_sys);
      ext_val <= 4'h4;
      settle();
      rchk(CPG_OFF_STAT, 32'h0000_0000);
      // per-pin access: index 1 set, out-of-range index refused
      wr(CPG_OFF_IBUF, PM);
      wr(CPG_OFF_OUT, 32'h0000_0000);
      wr(CPG_OFF_PACC, 32'h0000_0101);
      rchk(CPG_OFF_OUT, 32'h0000_0002);
      wr(CPG_OFF_PACC, 32'h0000_0105);
      rchk(CPG_OFF_OUT, 32'h0000_0002);
      wr(CPG_OFF_PACC, 32'h0000_0002);
      rchk(CPG_OFF_PACC, 32'h0000_0102);
      stop_test();
   end
endmodule

/* test/cpg_pad_model.sv */
// outside world on the pads: buttons with pull-ups and passive loads
// assumes the bench changes ext_en and ext_val just after clock edges
`timescale 1ns/10ps
module cpg_pad_model #(
   parameter int N = 4
) (
   input  wire logic [N-1:0] pad_out,
   input  wire logic [N-1:0] pad_oe,
   input  wire logic [N-1:0] ext_en,
   input  wire logic [N-1:0] ext_val,
   output logic [N-1:0]      pad_lvl
);
   // one shared terminal per pin; two drivers at once give contention
   always_comb begin
      for (int i = 0; i < N; i++) begin
         if (pad_oe[i] && ext_en[i])
            pad_lvl[i] = 1'bx;
         else if (pad_oe[i])
            pad_lvl[i] = pad_out[i];
         else if (ext_en[i])
            pad_lvl[i] = ext_val[i];
         else
            pad_lvl[i] = 1'b1; // released pad floats up, never holds
      end
   end
endmodule
